// *** ctt_bank.sv ***
// Purpose: throttle threshold and event option registers with event filters
// Assumes: comparators are analog, their outputs arrive asynchronously
// Notes: levels are driven out as digital codes for the comparator trims
`timescale 1ns/10ps
`default_nettype none
module ctt_bank
   import ctt_pkg::*;
#(
   parameter int CYC_CRIT2_P = ctt_pkg::CYC_CRIT2,
   parameter int CYC_CRIT3_P = ctt_pkg::CYC_CRIT3,
   parameter int CYC_CRIT1_P = ctt_pkg::CYC_CRIT1,
   parameter int CYC_NOM0_P = ctt_pkg::CYC_NOM0,
   parameter int CYC_NOM1_P = ctt_pkg::CYC_NOM1
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic single_cell,
   input wire logic peak_assist_mode,
   input wire logic crit_cmp,
   input wire logic nom_cmp,
   input wire logic droop_cmp,
   input wire logic sys_thr_cmp,
   input wire logic sys_dis_cmp,
   output logic [8:0] second_current_limit_level,
   output logic [12:0] critical_current_level,
   output logic [6:0] nominal_current_level,
   output logic [6:0] droop_threshold_pct,
   output logic [6:0] sys_voltage_discharge_level,
   output logic [6:0] sys_voltage_throttle_level,
   output logic bus_discharge,
   output logic [7:0] event_active,
   output logic cpu_throttle_output_n
);
   import ctt_pkg::*;

   // a count the filter counter cannot hold would be truncated to CNT_W bits and trip at the wrong count
   if (CYC_CRIT1_P < 1 || CYC_CRIT2_P < 1 || CYC_CRIT3_P < 1 || CYC_NOM0_P < 1
      || CYC_NOM1_P < 1 || CYC_NOM1_P >= (1 << CNT_W) || CYC_CRIT3_P >= (1 << CNT_W)
      || CYC_CRIT2_P >= (1 << CNT_W) || CYC_CRIT1_P >= (1 << CNT_W)
      || CYC_NOM0_P >= (1 << CNT_W))
   begin : g_bad_counts
      $error("ctt_bank: filter counts out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0] thr_r;
   logic [15:0] thr_nxt;
   logic [15:0] evt_r;
   logic [15:0] evt_nxt;
   logic [4:0] lim_eff_r;
   logic [4:0] lim_eff_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   always_comb
   begin
      thr_nxt = thr_r;
      evt_nxt = evt_r;
      rdata_nxt = rdata_r;
      if (reg_wr)
      begin
         case (reg_addr)
            ADDR_THR_LO: thr_nxt[7:0] = reg_wdata;
            ADDR_THR_HI: thr_nxt[15:8] = reg_wdata;
            ADDR_EVT_LO: evt_nxt[7:0] = reg_wdata;
            ADDR_EVT_HI: evt_nxt[15:8] = reg_wdata;
            default: thr_nxt = thr_r;
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_THR_LO: rdata_nxt = thr_r[7:0];
            ADDR_THR_HI: rdata_nxt = thr_r[15:8];
            ADDR_EVT_LO: rdata_nxt = evt_r[7:0];
            ADDR_EVT_HI: rdata_nxt = evt_r[15:8];
            default: rdata_nxt = 8'h00;
         endcase
      end
      // out-of-range code leaves the trip level where it was
      lim_eff_nxt = lim_eff_r;
      if (thr_r[F_LIM2_LSB +: 5] != LIM2_INVALID)
         lim_eff_nxt = thr_r[F_LIM2_LSB +: 5];
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         thr_r <= THR_RESET;
         evt_r <= EVT_RESET;
         lim_eff_r <= LIM2_RESET;
         rdata_r <= 8'h00;
      end
      else
      begin
         thr_r <= thr_nxt;
         evt_r <= evt_nxt;
         lim_eff_r <= lim_eff_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // threshold decode
   logic [8:0] lim_pct;
   logic [12:0] crit_x10;
   logic [6:0] droop_pct;
   logic [6:0] dis_dv;
   logic [6:0] thr_dv;
   logic [1:0] crit_sel;
   logic [1:0] sys_sel;
   logic sc1_r;
   logic sc2_r;

   always_comb
   begin
      if (lim_eff_r <= LIM2_FINE_LAST)
         lim_pct = 9'(LIM2_FINE_BASE + LIM2_FINE_STEP * int'(lim_eff_r));
      else
         lim_pct = 9'(LIM2_COARSE_BASE
                      + LIM2_COARSE_STEP * (int'(lim_eff_r) - int'(LIM2_FINE_LAST) - 1));
      crit_x10 = 13'(CRIT_RATIO_X10 * int'(lim_pct));
      if (!thr_r[F_DROOP_LOW])
         droop_pct = 7'(DROOP_FULL_PCT);
      else if (thr_r[F_DROOP_SEL])
         droop_pct = 7'(DROOP_HIGH_PCT);
      else
         droop_pct = 7'(DROOP_LOW_PCT);
      sys_sel = thr_r[F_THR_LSB +: 2];
      if (sc2_r)
      begin
         dis_dv = 7'(SINGLE_BASE_DV + int'(thr_r[F_DIS_LSB +: 3]));
         thr_dv = 7'(SINGLE_BASE_DV + SINGLE_THR_STEP_DV * int'(sys_sel));
      end
      else
      begin
         dis_dv = 7'(MULTI_BASE_DV + int'(thr_r[F_DIS_LSB +: 4]));
         thr_dv = 7'(MULTI_BASE_DV + MULTI_THR_STEP_DV * int'(sys_sel));
      end
      crit_sel = thr_r[F_CRIT_LSB +: 2];
   end

   ////////////////////////////////////////////////////////////////////////
   // comparator synchronisers and filters
   logic [NUM_EV-1:0] raw;
   logic [NUM_EV-1:0] sync1_r;
   logic [NUM_EV-1:0] sync2_r;
   logic [CNT_W-1:0] lim [NUM_EV];
   logic [NUM_EV-1:0] hit;

   assign raw = {sys_dis_cmp, sys_thr_cmp, droop_cmp, nom_cmp, crit_cmp};

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         sc1_r <= 1'b0;
         sc2_r <= 1'b0;
      end
      else
      begin
         sync1_r <= raw;
         sync2_r <= sync1_r;
         sc1_r <= single_cell;
         sc2_r <= sc1_r;
      end
   end

   always_comb
   begin
      case (crit_sel)
         2'b00: lim[0] = CNT_W'(CYC_CRIT0);
         2'b01: lim[0] = CNT_W'(CYC_CRIT1_P);
         2'b10: lim[0] = CNT_W'(CYC_CRIT2_P);
         default: lim[0] = CNT_W'(CYC_CRIT3_P);
      endcase
      if (thr_r[F_NOM_FILT])
         lim[1] = CNT_W'(CYC_NOM1_P);
      else
         lim[1] = CNT_W'(CYC_NOM0_P);
      // droop and rail comparisons share the fixed short filter
      lim[2] = CNT_W'(CYC_SYS);
      lim[3] = CNT_W'(CYC_SYS);
      lim[4] = CNT_W'(CYC_SYS);
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_EV; gi++)
      begin : g_filt
         ctt_filter #(.W(CNT_W)) u_filt (
            .clk_sys(clk_sys),
            .rst(rst),
            .level(sync2_r[gi]),
            .limit(lim[gi]),
            .hit(hit[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // event gating and outputs
   logic [7:0] act_nxt;
   logic [7:0] act_r;
   logic dis_r;
   logic thr_n_r;
   logic [8:0] lim_pct_r;
   logic [12:0] crit_r;
   logic [6:0] droop_r;
   logic [6:0] dis_dv_r;
   logic [6:0] thr_dv_r;
   logic dis_nxt;
   logic thr_n_nxt;
   logic [6:0] nom_r;

   always_comb
   begin
      act_nxt = 8'h00;
      act_nxt[E_CRIT] = hit[0] & evt_r[E_CRIT];
      act_nxt[E_NOM] = hit[1] & evt_r[E_NOM];
      act_nxt[E_DROOP] = hit[2] & evt_r[E_DROOP];
      act_nxt[E_SYS] = hit[3] & evt_r[E_SYS];
      dis_nxt = hit[4] & peak_assist_mode;
      thr_n_nxt = ~|act_nxt;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         act_r <= 8'h00;
         dis_r <= 1'b0;
         thr_n_r <= 1'b1;
         lim_pct_r <= 9'h000;
         crit_r <= 13'h0000;
         droop_r <= 7'h00;
         dis_dv_r <= 7'h00;
         thr_dv_r <= 7'h00;
         nom_r <= 7'h00;
      end
      else
      begin
         act_r <= act_nxt;
         dis_r <= dis_nxt;
         thr_n_r <= thr_n_nxt;
         lim_pct_r <= lim_pct;
         crit_r <= crit_x10;
         droop_r <= droop_pct;
         dis_dv_r <= dis_dv;
         thr_dv_r <= thr_dv;
         nom_r <= 7'(NOM_PCT);
      end
   end

   assign reg_rdata = rdata_r;
   assign second_current_limit_level = lim_pct_r;
   assign critical_current_level = crit_r;
   assign nominal_current_level = nom_r;
   assign droop_threshold_pct = droop_r;
   assign sys_voltage_discharge_level = dis_dv_r;
   assign sys_voltage_throttle_level = thr_dv_r;
   assign bus_discharge = dis_r;
   assign event_active = act_r;
   assign cpu_throttle_output_n = thr_n_r;
endmodule
`default_nettype wire

// *** ctt_bank_checker.sv ***
// Purpose: port checker for ctt_bank
// Assumes: bound into ctt_bank
// Notes: levels read 0 the first cycle after reset, so skipped there
`timescale 1ns/10ps
`default_nettype none
module ctt_bank_checker
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic crit_cmp,
   input wire logic peak_assist_mode,
   input wire logic [8:0] second_current_limit_level,
   input wire logic [12:0] critical_current_level,
   input wire logic [6:0] nominal_current_level,
   input wire logic [6:0] droop_threshold_pct,
   input wire logic bus_discharge,
   input wire logic [7:0] event_active,
   input wire logic cpu_throttle_output_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_nominal_fixed: assert property (!$past(rst) |-> nominal_current_level == 7'h6e)
      else $error("nominal level wrong");
   chk_crit_ratio: assert property (!$past(rst) |->
      critical_current_level == 13'(second_current_limit_level) * 13'h00b)
      else $error("critical level not 110 percent of limit");
   chk_limit_range: assert property (!$past(rst) |->
      second_current_limit_level inside {[9'h069:9'h0e6], [9'h0fa:9'h1c2]})
      else $error("limit level out of range");
   chk_droop_set: assert property (!$past(rst) |->
      droop_threshold_pct inside {7'h64, 7'h50, 7'h5a})
      else $error("droop level not 100, 80 or 90");
   chk_throttle_any: assert property (cpu_throttle_output_n == ~|event_active)
      else $error("throttle pin disagrees with events");
   chk_unused_events: assert property ((event_active & 8'h4b) == 8'h00)
      else $error("unsupported event bit set");
   chk_crit_release: assert property (!crit_cmp [*5] |-> !event_active[5])
      else $error("critical event outlives comparator");
   chk_discharge_gate: assert property (!peak_assist_mode [*3] |-> !bus_discharge)
      else $error("discharge outside peak assist");
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
endmodule
`default_nettype wire

// *** ctt_cmp_model.sv ***
// Purpose: comparator front model beside ctt_bank
// Assumes: bench sets the condition word
// Notes: registered, so levels move just after an edge
`timescale 1ns/10ps
`default_nettype none
module ctt_cmp_model
(
   input wire logic clk_sys,
   input wire logic [4:0] cond,
   output logic [4:0] cmp_r
);
   // bit0 crit, 1 nominal, 2 droop, 3 rail, 4 discharge
   always_ff @(posedge clk_sys)
   begin
      cmp_r <= cond;
   end
endmodule
`default_nettype wire

// *** ctt_filter.sv ***
// Purpose: continuous-assertion deglitch filter
// Assumes: input already synchronised to clk_sys
// Notes: any drop restarts timing
`timescale 1ns/10ps
`default_nettype none
module ctt_filter
#(
   parameter int W = 24
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic level,
   input wire logic [W-1:0] limit,
   output logic hit
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic hit_r;
   logic hit_nxt;

   // a one-bit counter cannot tell a short pulse from a filter span
   if (W < 2)
   begin : g_bad_width
      $error("ctt_filter: width too small");
   end

   always_comb
   begin
      cnt_nxt = cnt_r;
      hit_nxt = 1'b0;
      if (!level)
         cnt_nxt = '0;
      else if (cnt_r >= limit - W'(1))
         hit_nxt = 1'b1;
      else
         cnt_nxt = cnt_r + W'(1);
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cnt_r <= '0;
         hit_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         hit_r <= hit_nxt;
      end
   end

   assign hit = hit_r;
endmodule
`default_nettype wire

// *** ctt_pkg.sv ***
// Purpose: constants for the cpu throttle threshold configuration bank
// Assumes: 125 MHz system clock, byte-wide internal register port
// Notes: offsets are the byte subaddresses seen behind the serial port
package ctt_pkg;
   localparam int CLK_MHZ = 125;
   // byte subaddresses of the two 16-bit words
   localparam logic [7:0] ADDR_THR_LO = 8'h36;
   localparam logic [7:0] ADDR_THR_HI = 8'h37;
   localparam logic [7:0] ADDR_EVT_LO = 8'h38;
   localparam logic [7:0] ADDR_EVT_HI = 8'h39;
   localparam logic [15:0] THR_RESET = 16'h4a65;
   localparam logic [15:0] EVT_RESET = 16'h81a0;
   // field positions in throttle_threshold_option
   localparam int F_LIM2_LSB = 11;
   localparam int F_CRIT_LSB = 9;
   localparam int F_DROOP_SEL = 8;
   localparam int F_DIS_LSB = 4;
   localparam int F_THR_LSB = 2;
   localparam int F_NOM_FILT = 1;
   localparam int F_DROOP_LOW = 0;
   // event enable bit positions in throttle_event_option
   localparam int E_DROOP = 7;
   localparam int E_CRIT = 5;
   localparam int E_NOM = 4;
   localparam int E_SYS = 2;
   // second current limit level encoding
   localparam logic [4:0] LIM2_FINE_LAST = 5'h19;
   localparam logic [4:0] LIM2_INVALID = 5'h1f;
   localparam logic [4:0] LIM2_RESET = 5'h09;
   localparam int LIM2_FINE_BASE = 105;
   localparam int LIM2_FINE_STEP = 5;
   localparam int LIM2_COARSE_BASE = 250;
   localparam int LIM2_COARSE_STEP = 50;
   localparam int NOM_PCT = 110;
   localparam int CRIT_RATIO_X10 = 11;
   localparam int DROOP_FULL_PCT = 100;
   localparam int DROOP_LOW_PCT = 80;
   localparam int DROOP_HIGH_PCT = 90;
   // rail levels in 100 mV units
   localparam int MULTI_BASE_DV = 59;
   localparam int SINGLE_BASE_DV = 31;
   localparam int MULTI_THR_STEP_DV = 3;
   localparam int SINGLE_THR_STEP_DV = 2;
   // filter times
   localparam int T_CRIT0_US = 15;
   localparam int T_CRIT1_US = 100;
   localparam int T_CRIT2_US = 400;
   localparam int T_CRIT3_US = 800;
   localparam int T_NOM0_MS = 1;
   localparam int T_NOM1_MS = 50;
   localparam int T_SYS_US = 5;
   localparam int CYC_CRIT0 = T_CRIT0_US * CLK_MHZ;
   localparam int CYC_CRIT1 = T_CRIT1_US * CLK_MHZ;
   localparam int CYC_CRIT2 = T_CRIT2_US * CLK_MHZ;
   localparam int CYC_CRIT3 = T_CRIT3_US * CLK_MHZ;
   localparam int CYC_NOM0 = T_NOM0_MS * 1000 * CLK_MHZ;
   localparam int CYC_NOM1 = T_NOM1_MS * 1000 * CLK_MHZ;
   localparam int CYC_SYS = T_SYS_US * CLK_MHZ;
   localparam int NUM_EV = 5;
   localparam int CNT_W = 24;
endpackage

// *** ctt_unused_guard.sv ***
// Purpose: spare source slot, holds no logic
// Assumes: nothing refers to this file
// Notes: a stray module here would stand as a second top beside the bench

// *** tb.sv ***
// Purpose: self-checking bench for ctt_bank
// Assumes: byte register port, shortened filter counts
// Notes: comparator model adds one cycle before the synchroniser
`timescale 1ns/10ps
`default_nettype none
module tb;
   import ctt_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic single_cell = 1'b0;
   logic peak_assist_mode = 1'b0;
   logic [4:0] cmd = 5'h00;
   logic [4:0] cmp;
   logic [7:0] rdata;
   logic [8:0] lim;
   logic [12:0] crit;
   logic [6:0] nom, droop, dis, thr;
   logic bus_discharge;
   logic [7:0] event_active;
   logic cpu_throttle_output_n;
   int n_errors = 0;
   int tests_run = 0;
   logic [4:0] lc [4] = '{5'h01, 5'h19, 5'h1a, 5'h1e};
   logic [8:0] lp [4] = '{9'h06e, 9'h0e6, 9'h0fa, 9'h1c2};
   int cn [4] = '{CYC_CRIT0, 20, 40, 80};
   always #4 clk_sys = ~clk_sys;
   ctt_cmp_model i_ctt_cmp_model (.clk_sys(clk_sys), .cond(cmd), .cmp_r(cmp));
   ctt_bank #(.CYC_CRIT1_P(20), .CYC_CRIT2_P(40), .CYC_CRIT3_P(80), .CYC_NOM0_P(50),
      .CYC_NOM1_P(100)) i_ctt_bank (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
      .single_cell(single_cell), .peak_assist_mode(peak_assist_mode), .crit_cmp(cmp[0]),
      .nom_cmp(cmp[1]), .droop_cmp(cmp[2]), .sys_thr_cmp(cmp[3]), .sys_dis_cmp(cmp[4]),
      .second_current_limit_level(lim), .critical_current_level(crit),
      .nominal_current_level(nom), .droop_threshold_pct(droop),
      .sys_voltage_discharge_level(dis), .sys_voltage_throttle_level(thr),
      .bus_discharge(bus_discharge), .event_active(event_active),
      .cpu_throttle_output_n(cpu_throttle_output_n));
   ////////////////////////////////////////////////////////////////////////////////
   task complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      cyc(3);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      check(rdata, e, "rdata");
   endtask
   // hold a condition n cycles: still quiet, then event and pin low, then gone
   task ev(input logic [4:0] c, input int b, input int n);
      @(posedge clk_sys) cmd <= c;
      cyc(n);
      check(event_active[b], 1'b0, "early event");
      cyc(6);
      check(event_active[b], 1'b1, "event");
      check(cpu_throttle_output_n, 1'b0, "throttle pin");
      @(posedge clk_sys) cmd <= 5'h00;
      cyc(6);
      check(event_active[b], 1'b0, "event drop");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #400000;
      n_errors++;
      complete_run;
   end
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      cyc(3);
      rd(8'h36, 8'h65);
      rd(8'h37, 8'h4a);
      rd(8'h38, 8'ha0);
      rd(8'h39, 8'h81);
      rd(8'h3a, 8'h00);
      check(lim, 9'h096, "limit");
      check(crit, 13'h0672, "crit");
      check(nom, 7'h6e, "nominal");
      check(droop, 7'h50, "droop");
      check(dis, 7'h41, "discharge");
      check(thr, 7'h3e, "rail");
      $display("test reset done");
      foreach (lc[i])
      begin
         wr(8'h37, {lc[i], 3'h2});
         check(lim, lp[i], "limit");
         check(crit, 13'(lp[i]) * 13'h00b, "crit");
      end
      wr(8'h37, 8'hfa);
      check(lim, 9'h1c2, "limit kept");
      rd(8'h37, 8'hfa);
      $display("test limit done");
      wr(8'h36, 8'h64);
      check(droop, 7'h64, "droop");
      wr(8'h37, 8'h4b);
      wr(8'h36, 8'h65);
      check(droop, 7'h5a, "droop");
      wr(8'h37, 8'h4a);
      check(droop, 7'h50, "droop");
      $display("test droop done");
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk_sys) single_cell <= s[0];
         for (int d = 0; d < 16; d++)
         begin
            wr(8'h36, {d[3:0], d[1:0], 2'h1});
            check(dis, s ? 31 + d % 8 : 59 + d, "discharge");
            check(thr, s ? 31 + 2 * (d % 4) : 59 + 3 * (d % 4), "rail");
         end
      end
      @(posedge clk_sys) single_cell <= 1'b0;
      wr(8'h36, 8'h65);
      $display("test rail done");
      wr(8'h38, 8'hb4);
      rd(8'h38, 8'hb4);
      foreach (cn[i])
      begin
         wr(8'h37, {5'h09, i[1:0], 1'b0});
         ev(5'h01, 5, cn[i]);
      end
      // broken high time must restart the count
      @(posedge clk_sys) cmd <= 5'h01;
      cyc(60);
      @(posedge clk_sys) cmd <= 5'h00;
      cyc(3);
      @(posedge clk_sys) cmd <= 5'h01;
      cyc(60);
      check(event_active[5], 1'b0, "restart");
      cyc(30);
      check(event_active[5], 1'b1, "crit");
      wr(8'h38, 8'h94);
      check(event_active[5], 1'b0, "masked");
      check(cpu_throttle_output_n, 1'b1, "masked pin");
      @(posedge clk_sys) cmd <= 5'h00;
      wr(8'h38, 8'hb4);
      wr(8'h36, 8'h67);
      ev(5'h02, 4, 100);
      wr(8'h36, 8'h65);
      ev(5'h02, 4, 50);
      ev(5'h04, 7, CYC_SYS);
      ev(5'h08, 2, CYC_SYS);
      $display("test events done");
      @(posedge clk_sys);
      peak_assist_mode <= 1'b1;
      cmd <= 5'h10;
      cyc(CYC_SYS);
      check(bus_discharge, 1'b0, "discharge early");
      cyc(6);
      check(bus_discharge, 1'b1, "discharge");
      @(posedge clk_sys) peak_assist_mode <= 1'b0;
      cyc(4);
      check(bus_discharge, 1'b0, "discharge off");
      @(posedge clk_sys) cmd <= 5'h00;
      $display("test discharge done");
      complete_run;
   end
endmodule
bind ctt_bank ctt_bank_checker i_ctt_bank_checker (.clk_sys(clk_sys), .rst(rst),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crit_cmp(crit_cmp),
   .peak_assist_mode(peak_assist_mode),
   .second_current_limit_level(second_current_limit_level),
   .critical_current_level(critical_current_level),
   .nominal_current_level(nominal_current_level), .droop_threshold_pct(droop_threshold_pct),
   .bus_discharge(bus_discharge), .event_active(event_active),
   .cpu_throttle_output_n(cpu_throttle_output_n));
`default_nettype wire
